// ---- common/pfrc_defs.vh ----
// constants for the power-fail and reset control block
// assumes an 8-bit special function register port with one-cycle strobes
//
// Overview of operation
// - enabled supply warning raises the power-fail interrupt, vector 33h.
// - warning flag bit 4 sets on low supply, re-sets while low persists.
// - software writing 1 to warning flag forces interrupt when enabled.
// - supply below reset threshold resets, except Stop with bandgap select 0.
// - during power-fail reset, halt and hold outputs in reset state.
// - power-up waits for supply, then counts 65,536 oscillator clocks, restarting on dips.
// - external clock source also starts counting once supply exceeds threshold.
// - count done releases reset itself; execution starts at vector 0000h.
// - power-up flag bit 6 set on power-on reset, kept until software clears.
// - Stop disables bandgap; no power-fail interrupt or reset then.
// - bandgap select bit 0 set keeps monitor active in Stop.
// - bandgap select defaults to 0.
// - timeout flag bit 3 sets on timeout; reset follows 512 clocks later unless restarted.
// - watchdog reset flag bit 2 set on watchdog reset, cleared by software or power-fail.
// - watchdog reset enable bit 1 permits reset; cleared, timer still runs.
// - restart bit 0 written 1 restarts timeout and self-clears.
// - watchdog interrupt requested only when interrupt enable bit 4 set.
// - clock status bit 2 reads 1 on ring oscillator, 0 on crystal.
// - ring select set: resume on ring at once, switch to crystal after 65,536.
// - ring select 0: hold execution after Stop exit for 65,536 crystal clocks.
// - ring select cleared by power-on or power-fail reset, or by software writing 0.
// - Stop bit 1 halts and stops clocks; Idle bit 0 halts only execution.
// - enabled interrupt ending Idle clears the Idle bit and vectors.
`ifndef PFRC_DEFS_VH
`define PFRC_DEFS_VH
`define PFRC_ADDR_CPU_PWR   8'h87
`define PFRC_ADDR_EXT_FLAGS 8'h91
`define PFRC_ADDR_DOG_PWR   8'hd8
`define PFRC_ADDR_IRQ_EN    8'he8
`define PFRC_BIT_IDLE       0
`define PFRC_BIT_STOP       1
`define PFRC_BIT_BANDGAP    0
`define PFRC_BIT_RINGSEL    1
`define PFRC_BIT_RINGACT    2
`define PFRC_BIT_RESTART    0
`define PFRC_BIT_DOGRSTEN   1
`define PFRC_BIT_DOGRSTFL   2
`define PFRC_BIT_DOGTOFL    3
`define PFRC_BIT_WARNFL     4
`define PFRC_BIT_WARNEN     5
`define PFRC_BIT_PWRUP      6
`define PFRC_BIT_DOGIRQEN   4
`define PFRC_WARN_VECTOR    16'h0033
`define PFRC_RESET_VECTOR   16'h0000
`define PFRC_STARTUP_CLKS   65536
`define PFRC_DOG_GRACE_CLKS 512
`define PFRC_IRQ_EN_RESET   8'h00
`endif

// ---- design/pfrc_power_fail_reset_control.v ----
// power-fail warning, power-on reset, watchdog status and Stop/Idle control
// assumes comparator levels are synchronous-sampled here, and the core takes core_reset_o/halt_o
`timescale 1ns/100ps
`include "pfrc_defs.vh"
module pfrc_power_fail_reset_control #(
    parameter STARTUP_CLKS = `PFRC_STARTUP_CLKS,
    parameter GRACE_CLKS   = `PFRC_DOG_GRACE_CLKS
) (
    input  wire       mclk_i,
    input  wire       reset_n_i,
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    input  wire       supply_warn_low_i,
    input  wire       supply_reset_low_i,
    input  wire       osc_tick_i,
    input  wire       dog_timeout_i,
    input  wire       wake_irq_i,
    input  wire       irq_ack_i,
    output wire       dog_count_restart_o,
    output wire       core_reset_o,
    output wire       cpu_halt_o,
    output wire       clocks_stopped_o,
    output wire       bandgap_enable_o,
    output wire       osc_enable_o,
    output wire       ring_clock_o,
    output wire       warn_irq_o,
    output wire       dog_irq_o,
    output reg  [15:0] vector_o,
    output reg        vector_valid_o
);
    localparam ST_OFF   = 2'd0;
    localparam ST_COUNT = 2'd1;
    localparam ST_RUN   = 2'd2;
    localparam ST_WAKE  = 2'd3;

    reg [1:0]  warn_sync_reg;
    reg [1:0]  rst_sync_reg;
    reg        warn_prev_reg;
    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [16:0] count_reg;
    reg        pwrup_reg;
    reg        warn_en_reg;
    reg        warn_flag_reg;
    reg        dog_to_flag_reg;
    reg        dog_rst_flag_reg;
    reg        dog_rst_en_reg;
    reg        restart_reg;
    reg        bandgap_keep_reg;
    reg        ring_sel_reg;
    reg        ring_act_reg;
    reg        idle_reg;
    reg        stop_reg;
    reg [7:0]  irq_en_reg;
    reg [9:0]  grace_reg;
    reg        grace_run_reg;
    reg        dog_reset_reg;
    reg        warn_pend_reg;
    reg        warn_vec_done_reg;

    wire warn_low  = warn_sync_reg[1];
    wire rst_low   = rst_sync_reg[1];
    wire monitor   = ~stop_reg | bandgap_keep_reg;
    wire pf_reset  = rst_low & monitor;
    wire warn_edge = monitor & warn_low & ~warn_prev_reg;
    wire wr_dog    = wr_i && (addr_i == `PFRC_ADDR_DOG_PWR);
    wire wr_flags  = wr_i && (addr_i == `PFRC_ADDR_EXT_FLAGS);
    wire wr_pwr    = wr_i && (addr_i == `PFRC_ADDR_CPU_PWR);
    wire wr_irqen  = wr_i && (addr_i == `PFRC_ADDR_IRQ_EN);
    wire force_irq = wr_dog & wdata_i[`PFRC_BIT_WARNFL];
    wire cnt_done  = (count_reg == STARTUP_CLKS[16:0] - 17'd1) & osc_tick_i;
    wire grace_end = grace_run_reg && (grace_reg == GRACE_CLKS[9:0] - 10'd1);

    assign core_reset_o        = (state_reg == ST_OFF) | (state_reg == ST_COUNT) | dog_reset_reg;
    // ring wake runs code at once; crystal wake holds the core until the count ends
    assign cpu_halt_o          = core_reset_o | idle_reg | stop_reg | ((state_reg == ST_WAKE) & ~ring_act_reg);
    assign clocks_stopped_o    = stop_reg;
    assign bandgap_enable_o    = monitor;
    assign osc_enable_o        = (state_reg != ST_OFF) & ~stop_reg;
    assign ring_clock_o        = ring_act_reg;
    assign warn_irq_o          = warn_en_reg & warn_pend_reg;
    assign dog_irq_o           = irq_en_reg[`PFRC_BIT_DOGIRQEN] & dog_to_flag_reg;
    assign dog_count_restart_o = restart_reg;

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            warn_sync_reg <= 2'b00;
            rst_sync_reg  <= 2'b11;
            warn_prev_reg <= 1'b0;
        end else begin
            warn_sync_reg <= {warn_sync_reg[0], supply_warn_low_i};
            rst_sync_reg  <= {rst_sync_reg[0], supply_reset_low_i};
            warn_prev_reg <= warn_low;
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF:   if (!rst_low) state_next = ST_COUNT;
            ST_COUNT: if (rst_low) state_next = ST_OFF;
                      else if (cnt_done) state_next = ST_RUN;
            ST_RUN:   if (pf_reset) state_next = ST_OFF;
                      else if (stop_reg && wake_irq_i) state_next = ST_WAKE;
            ST_WAKE:  if (pf_reset) state_next = ST_OFF;
                      else if (cnt_done) state_next = ST_RUN;
            default:  state_next = ST_OFF;
        endcase
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_OFF;
            count_reg <= 17'd0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg)
                count_reg <= 17'd0;
            else if (osc_tick_i && (state_reg == ST_COUNT || state_reg == ST_WAKE))
                count_reg <= count_reg + 17'd1;
        end
    end

    // watchdog grace window after timeout
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            grace_reg     <= 10'd0;
            grace_run_reg <= 1'b0;
            dog_reset_reg <= 1'b0;
        end else begin
            dog_reset_reg <= grace_end & dog_rst_en_reg;
            if (core_reset_o || restart_reg || grace_end) begin
                grace_run_reg <= 1'b0;
                grace_reg     <= 10'd0;
            end else if (dog_timeout_i && !grace_run_reg) begin
                grace_run_reg <= 1'b1;
            end else if (grace_run_reg) begin
                grace_reg <= grace_reg + 10'd1;
            end
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwrup_reg        <= 1'b0;
            warn_en_reg      <= 1'b0;
            warn_flag_reg    <= 1'b0;
            warn_pend_reg    <= 1'b0;
            dog_to_flag_reg  <= 1'b0;
            dog_rst_flag_reg <= 1'b0;
            dog_rst_en_reg   <= 1'b0;
            restart_reg      <= 1'b0;
            bandgap_keep_reg <= 1'b0;
            ring_sel_reg     <= 1'b0;
            ring_act_reg     <= 1'b0;
            idle_reg         <= 1'b0;
            stop_reg         <= 1'b0;
            irq_en_reg       <= `PFRC_IRQ_EN_RESET;
        end else if (state_reg == ST_OFF) begin
            // power-fail/power-on reset: everything back to reset state, except the power-up flag, which sets
            pwrup_reg        <= 1'b1;
            warn_en_reg      <= 1'b0;
            warn_flag_reg    <= 1'b0;
            warn_pend_reg    <= 1'b0;
            dog_to_flag_reg  <= 1'b0;
            dog_rst_flag_reg <= 1'b0;
            dog_rst_en_reg   <= 1'b0;
            restart_reg      <= 1'b0;
            bandgap_keep_reg <= 1'b0;
            ring_sel_reg     <= 1'b0;
            ring_act_reg     <= 1'b0;
            idle_reg         <= 1'b0;
            stop_reg         <= 1'b0;
            irq_en_reg       <= `PFRC_IRQ_EN_RESET;
        end else begin
            restart_reg <= wr_dog & wdata_i[`PFRC_BIT_RESTART];
            if (wr_dog) begin
                pwrup_reg      <= pwrup_reg & wdata_i[`PFRC_BIT_PWRUP];
                warn_en_reg    <= wdata_i[`PFRC_BIT_WARNEN];
                dog_rst_en_reg <= wdata_i[`PFRC_BIT_DOGRSTEN];
            end
            // set wins over software clear
            if (warn_low && monitor)
                warn_flag_reg <= 1'b1;
            else if (wr_dog)
                warn_flag_reg <= wdata_i[`PFRC_BIT_WARNFL];
            if (warn_edge || force_irq)
                warn_pend_reg <= 1'b1;
            else if (irq_ack_i || (wr_dog && !wdata_i[`PFRC_BIT_WARNFL]))
                warn_pend_reg <= 1'b0;
            if (dog_timeout_i)
                dog_to_flag_reg <= 1'b1;
            else if (dog_reset_reg)
                dog_to_flag_reg <= 1'b0;
            else if (wr_dog)
                dog_to_flag_reg <= dog_to_flag_reg & wdata_i[`PFRC_BIT_DOGTOFL];
            if (grace_end && dog_rst_en_reg)
                dog_rst_flag_reg <= 1'b1;
            else if (wr_dog)
                dog_rst_flag_reg <= dog_rst_flag_reg & wdata_i[`PFRC_BIT_DOGRSTFL];
            if (wr_flags) begin
                bandgap_keep_reg <= wdata_i[`PFRC_BIT_BANDGAP];
                ring_sel_reg     <= wdata_i[`PFRC_BIT_RINGSEL];
            end
            if (wr_irqen)
                irq_en_reg <= wdata_i;
            // with ring select set, ring oscillator runs from Stop exit until crystal count ends
            if (state_reg == ST_RUN && state_next == ST_WAKE)
                ring_act_reg <= ring_sel_reg;
            else if (state_reg == ST_WAKE && cnt_done)
                ring_act_reg <= 1'b0;
            if (dog_reset_reg) begin
                idle_reg <= 1'b0;
                stop_reg <= 1'b0;
            end else if (stop_reg && wake_irq_i) begin
                stop_reg <= 1'b0;
            end else if (idle_reg && wake_irq_i) begin
                idle_reg <= 1'b0;
            end else if (wr_pwr) begin
                stop_reg <= wdata_i[`PFRC_BIT_STOP];
                idle_reg <= wdata_i[`PFRC_BIT_IDLE];
            end
        end
    end

    // vector request: reset vector at release wins over the power-fail interrupt vector
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vector_o          <= `PFRC_RESET_VECTOR;
            vector_valid_o    <= 1'b0;
            warn_vec_done_reg <= 1'b0;
        end else if (state_reg == ST_COUNT && state_next == ST_RUN) begin
            vector_o       <= `PFRC_RESET_VECTOR;
            vector_valid_o <= 1'b1;
        end else if (warn_irq_o && !core_reset_o && !warn_vec_done_reg) begin
            // one vector per pending request, re-armed once the request is gone
            vector_o          <= `PFRC_WARN_VECTOR;
            vector_valid_o    <= 1'b1;
            warn_vec_done_reg <= 1'b1;
        end else begin
            vector_valid_o <= 1'b0;
            if (!warn_pend_reg)
                warn_vec_done_reg <= 1'b0;
        end
    end

    // ring_act_reg only changes outside ST_RUN writes; ring_wake_select read back is software value
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            if (addr_i == `PFRC_ADDR_DOG_PWR)
                rdata_o <= {1'b0, pwrup_reg, warn_en_reg, warn_flag_reg, dog_to_flag_reg,
                            dog_rst_flag_reg, dog_rst_en_reg, 1'b0};
            else if (addr_i == `PFRC_ADDR_EXT_FLAGS)
                rdata_o <= {5'h00, ring_act_reg, ring_sel_reg, bandgap_keep_reg};
            else if (addr_i == `PFRC_ADDR_CPU_PWR)
                rdata_o <= {6'h00, stop_reg, idle_reg};
            else if (addr_i == `PFRC_ADDR_IRQ_EN)
                rdata_o <= irq_en_reg;
            else
                rdata_o <= 8'h00;
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule

// ---- dv/pfrc_power_fail_reset_control_asserts.sv ----
// concurrent checks on the power-fail and reset control ports
// assumes one clock domain and the async active-low reset
`timescale 1ns/100ps
module pfrc_checker #(
    parameter STARTUP_CLKS = 16,
    parameter GRACE_CLKS   = 8
) (
    input wire logic        mclk_i,
    input wire logic        reset_n_i,
    input wire logic [7:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        supply_reset_low_i,
    input wire logic        dog_count_restart_o,
    input wire logic        core_reset_o,
    input wire logic        cpu_halt_o,
    input wire logic        clocks_stopped_o,
    input wire logic        bandgap_enable_o,
    input wire logic        warn_irq_o,
    input wire logic        dog_irq_o,
    input wire logic [15:0] vector_o,
    input wire logic        vector_valid_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    a_read_slot_only: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data outside read slot");
    a_unmapped_reads_zero: assert property ((rd_i && !(addr_i inside {8'h87, 8'h91, 8'hd8, 8'he8}))
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    // four cycles covers the two sync flops plus the state register
    a_low_supply_resets: assert property ((supply_reset_low_i && !clocks_stopped_o) [*4]
        |-> core_reset_o) else $error("low supply without reset");
    a_reset_halts: assert property (core_reset_o |-> cpu_halt_o) else $error("reset without halt");
    a_reset_quiets: assert property ((core_reset_o && $past(core_reset_o))
        |-> !warn_irq_o && !dog_irq_o) else $error("interrupt during reset");
    a_stop_halts: assert property (clocks_stopped_o |-> cpu_halt_o) else $error("stop without halt");
    a_bandgap_awake: assert property (!clocks_stopped_o |-> bandgap_enable_o) else $error("bandgap off while running");
    a_vector_fixed: assert property (vector_valid_o
        |-> (vector_o == 16'h0033 || vector_o == 16'h0000)) else $error("unexpected vector");
    a_restart_pulse: assert property ((wr_i && addr_i == 8'hd8 && wdata_i[0] && !core_reset_o)
        |=> dog_count_restart_o) else $error("restart pulse missing");
    a_restart_self_clear: assert property (!(wr_i && addr_i == 8'hd8 && wdata_i[0])
        |=> !dog_count_restart_o) else $error("restart pulse not self-clearing");
endmodule

bind pfrc_power_fail_reset_control pfrc_checker #(
    .STARTUP_CLKS(STARTUP_CLKS), .GRACE_CLKS(GRACE_CLKS)
) u_chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .supply_reset_low_i(supply_reset_low_i),
    .dog_count_restart_o(dog_count_restart_o), .core_reset_o(core_reset_o), .cpu_halt_o(cpu_halt_o),
    .clocks_stopped_o(clocks_stopped_o), .bandgap_enable_o(bandgap_enable_o), .warn_irq_o(warn_irq_o),
    .dog_irq_o(dog_irq_o), .vector_o(vector_o), .vector_valid_o(vector_valid_o)
);

// ---- dv/pfrc_supply_model.sv ----
// behavioural supply comparators and oscillator tick source
// assumes the bench sets level (0 below reset, 1 below warning, 2 good) and tick_gap
`timescale 1ns/100ps
module pfrc_supply_model (
    input  wire logic mclk_i,
    output logic      warn_low_o,
    output logic      reset_low_o,
    output logic      osc_tick_o
);
    integer level;
    integer tick_gap;
    integer div;
    initial begin
        level = 0;
        tick_gap = 1;
        div = 0;
        warn_low_o = 1'b1;
        reset_low_o = 1'b1;
        osc_tick_o = 1'b0;
    end
    always @(posedge mclk_i) begin
        div = (div + 1) % tick_gap;
        // reset threshold sits below the warning one, so reset level implies warning
        reset_low_o <= (level == 0);
        warn_low_o  <= (level <= 1);
        osc_tick_o  <= (div == 0);
    end
endmodule

// ---- dv/test_pfrc_power_fail_reset_control.sv ----
// self-checking bench for the power-fail and reset control block
// assumes the supply model drives comparator and tick inputs
`timescale 1ns/100ps
module test_pfrc_power_fail_reset_control;
    localparam int SC = 16;
    localparam int GC = 8;
    logic        mclk_i, reset_n_i, wr_i, rd_i, dog_timeout_i, wake_irq_i, irq_ack_i;
    logic [7:0]  addr_i, wdata_i, rv, d;
    wire  [7:0]  rdata_o;
    wire  [15:0] vector_o;
    wire         wl, rl, tk, rst_pulse, core_reset_o, cpu_halt_o, stp, bg, ring, wirq, dirq, vv, osc;
    integer      mismatches, check_count, seed, rcyc, snap, i;
    logic [15:0] vq[$];
    pfrc_power_fail_reset_control #(.STARTUP_CLKS(SC), .GRACE_CLKS(GC)) u_dut (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .supply_warn_low_i(wl), .supply_reset_low_i(rl), .osc_tick_i(tk), .dog_timeout_i(dog_timeout_i),
        .wake_irq_i(wake_irq_i), .irq_ack_i(irq_ack_i), .dog_count_restart_o(rst_pulse),
        .core_reset_o(core_reset_o), .cpu_halt_o(cpu_halt_o), .clocks_stopped_o(stp), .bandgap_enable_o(bg),
        .osc_enable_o(osc), .ring_clock_o(ring), .warn_irq_o(wirq), .dog_irq_o(dirq), .vector_o(vector_o),
        .vector_valid_o(vv));
    pfrc_supply_model u_sup (.mclk_i(mclk_i), .warn_low_o(wl), .reset_low_o(rl), .osc_tick_o(tk));
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        if (vv === 1'b1) vq.push_back(vector_o);
        if (core_reset_o === 1'b1) rcyc = rcyc + 1;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_vec(input logic [15:0] e);
        chk("vector", e, (vq.size() > 0) ? vq.pop_front() : 16'hxxxx);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic ticks(input int n);
        int k;
        k = 0;
        while (k < n) begin
            @(posedge mclk_i);
            if (tk === 1'b1) k++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // rdata stands only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge mclk_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
        chk("register", {8'h00, e}, {8'h00, rv & m});
    endtask
    task automatic pulse(input int w);
        @(posedge mclk_i);
        if (w == 0) dog_timeout_i <= 1'b1; else if (w == 1) wake_irq_i <= 1'b1; else irq_ack_i <= 1'b1;
        @(posedge mclk_i);
        dog_timeout_i <= 1'b0; wake_irq_i <= 1'b0; irq_ack_i <= 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        give_verdict;
    end
    initial begin
        {reset_n_i, wr_i, rd_i, dog_timeout_i, wake_irq_i, irq_ack_i} = 6'h00;
        addr_i = 8'h00; wdata_i = 8'h00; mismatches = 0; check_count = 0; rcyc = 0; seed = 32'h6b21;
        cyc(20);
        reset_n_i <= 1'b1;
        cyc(5);
        u_sup.level <= 2;
        ticks(10);
        u_sup.level <= 0;
        cyc(4);
        u_sup.level <= 2;
        ticks(SC - 1);
        chk("count restarts", 1, core_reset_o);
        chk("osc on", 1, osc);
        cyc(10);
        chk("released", 0, core_reset_o);
        chk_vec(16'h0000);
        rchk(8'hd8, 8'h40, 8'hff);
        rchk(8'h91, 8'h00, 8'hff);
        rchk(8'h87, 8'h00, 8'hff);
        rchk(8'h55, 8'h00, 8'hff);
        wr(8'hd8, 8'h00);
        rchk(8'hd8, 8'h00, 8'hff);
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(8'he8, d);
            rchk(8'he8, d, 8'hff);
        end
        wr(8'hd8, 8'h20);
        u_sup.level <= 1;
        cyc(5);
        chk("warn irq", 1, wirq);
        rchk(8'hd8, 8'h30, 8'hff);
        chk_vec(16'h0033);
        pulse(2);
        wr(8'hd8, 8'h20);
        cyc(3);
        rchk(8'hd8, 8'h30, 8'hff);
        u_sup.level <= 2;
        cyc(4);
        wr(8'hd8, 8'h20);
        pulse(2);
        rchk(8'hd8, 8'h20, 8'hff);
        wr(8'hd8, 8'h30);
        cyc(2);
        chk("forced irq", 1, wirq);
        pulse(2);
        wr(8'hd8, 8'h10);
        cyc(2);
        chk("masked irq", 0, wirq);
        wr(8'h91, 8'h02);
        wr(8'he8, 8'h10);
        wr(8'hd8, 8'h02);
        pulse(0);
        wr(8'hd8, 8'h03);
        snap = rcyc;
        chk("dog irq", 1, dirq);
        cyc(GC + 4);
        chk("restart holds off", snap, rcyc);
        wr(8'he8, 8'h00);
        pulse(0);
        cyc(1);
        chk("dog irq off", 0, dirq);
        cyc(GC + 3);
        chk("dog reset", snap + 1, rcyc);
        rchk(8'hd8, 8'h04, 8'h0c);
        rchk(8'h91, 8'h02, 8'h02);
        wr(8'hd8, 8'h00);
        pulse(0);
        cyc(GC + 4);
        chk("no dog reset", snap + 1, rcyc);
        rchk(8'hd8, 8'h08, 8'h0c);
        u_sup.tick_gap <= 3;
        wr(8'h87, 8'h02);
        cyc(1);
        chk("stopped", 1, stp);
        chk("osc off", 0, osc);
        chk("bandgap off", 0, bg);
        u_sup.level <= 0;
        cyc(6);
        chk("no stop reset", 0, core_reset_o);
        u_sup.level <= 2;
        cyc(4);
        pulse(1);
        cyc(2);
        chk("ring resume", 1, ring);
        chk("ring runs", 0, cpu_halt_o);
        ticks(SC + 4);
        cyc(2);
        chk("crystal back", 0, ring);
        chk("running", 0, cpu_halt_o);
        wr(8'h91, 8'h01);
        rchk(8'h91, 8'h01, 8'h07);
        wr(8'h87, 8'h02);
        cyc(1);
        chk("bandgap kept", 1, bg);
        pulse(1);
        cyc(3);
        chk("crystal wait", 1, cpu_halt_o);
        chk("no ring", 0, ring);
        ticks(SC + 4);
        chk("woke", 0, cpu_halt_o);
        wr(8'h87, 8'h01);
        cyc(1);
        chk("idle halt", 1, cpu_halt_o);
        chk("idle clocks", 0, stp);
        pulse(1);
        cyc(2);
        rchk(8'h87, 8'h00, 8'hff);
        wr(8'h91, 8'h03);
        u_sup.level <= 0;
        cyc(6);
        chk("power reset", 1, core_reset_o);
        u_sup.level <= 2;
        ticks(SC + 6);
        rchk(8'hd8, 8'h40, 8'hff);
        rchk(8'h91, 8'h00, 8'hff);
        give_verdict;
    end
endmodule
